// ==== aisd_cfg.svh ====
/*
 * Constants for the input select and test decoder: word layout, reset values, codes.
 * Assumes inclusion by the design modules; definitions only.
 */
`ifndef AISD_CFG_SVH
`define AISD_CFG_SVH

`define AISD_DATA_W      10
`define AISD_IDX_WORD0   2'h0
`define AISD_BIT_PICK    3
`define AISD_BIT_PAIR    5
`define AISD_BIT_SCAN    7
`define AISD_BIT_TEST    8
`define AISD_RESET_WORD  10'h020
`define AISD_CODE_TOP_BIN   10'h3FF
`define AISD_CODE_MID_BIN   10'h200
`define AISD_CODE_BOT_BIN   10'h000
`define AISD_CODE_TOP_TWOS  10'h1FF
`define AISD_CODE_MID_TWOS  10'h000
`define AISD_CODE_BOT_TWOS  10'h200

`endif

// ==== aisd_core.sv ====
/*
 * Input select and test decoder: holds control word zero, steps the autoscan
 * sequence on each sample strobe and reports the input or test code to convert.
 * Assumes a host writes with wr_i one cycle, index and data stable that cycle,
 * and that sample_i pulses once per conversion from the sampling clock.
 */
`include "aisd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module aisd_core
	import aisd_pkg::*;
#(
	parameter int DATA_W = `AISD_DATA_W
) (
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	input  wire logic              wr_i,
	input  wire logic              reg_index_lo_i,
	input  wire logic              reg_index_hi_i,
	input  wire logic [DATA_W-1:0] data_i,
	input  wire logic              sample_i,
	input  wire logic              twos_i,
	output aisd_src_t              src_o,
	output logic                   test_on_o,
	output logic [DATA_W-1:0]      test_code_o,
	output logic                   scanning_o,
	output logic                   reserved_o,
	output logic                   step_o,
	output logic [DATA_W-1:0]      word_o
);
	logic [DATA_W-1:0] word;
	logic [DATA_W-1:0] next_word;
	aisd_step_t        step;
	aisd_step_t        next_step;
	aisd_sel_t         sel;
	aisd_test_t        test;
	aisd_src_t         tbl_src;
	logic [1:0]        tbl_len;
	logic              tbl_res;
	aisd_src_t         next_src;
	logic              next_test_on;
	logic [DATA_W-1:0] next_test_code;
	logic              next_scanning;
	logic              next_step_pulse;
	logic              write0;

	assign write0 = wr_i && ({reg_index_hi_i, reg_index_lo_i} == `AISD_IDX_WORD0);
	assign sel    = aisd_sel_t'(word[`AISD_BIT_SCAN:`AISD_BIT_PICK]);
	assign test   = aisd_test_t'(word[`AISD_BIT_TEST+1:`AISD_BIT_TEST]);

	aisd_seq_table u_table (
		.sel_i      (sel),
		.step_i     (step),
		.src_o      (tbl_src),
		.len_o      (tbl_len),
		.reserved_o (tbl_res)
	);

	function automatic aisd_step_t step_after(input aisd_step_t s, input logic [1:0] last);
		aisd_step_t n;
		n = AISD_ST0;
		case (s)
			AISD_ST0: n = (last == 2'h0) ? AISD_ST0 : AISD_ST1;
			AISD_ST1: n = (last == 2'h1) ? AISD_ST0 : AISD_ST2;
			AISD_ST2: n = (last == 2'h2) ? AISD_ST0 : AISD_ST3;
			AISD_ST3: n = AISD_ST0;
			default:  n = AISD_ST0;
		endcase
		return n;
	endfunction

	always_comb begin
		next_word = word;
		next_step = step;
		next_step_pulse = 1'b0;
		if (write0) begin
			next_word = data_i;
			next_step = AISD_ST0; // New selection restarts at step AISD_ST0
		end else if (sample_i && (tbl_len != 2'h0)) begin
			next_step = step_after(step, tbl_len);
			next_step_pulse = 1'b1;
		end else if (tbl_len == 2'h0) begin
			next_step = AISD_ST0;
		end
	end

	always_comb begin
		next_src       = tbl_src;
		next_scanning  = (tbl_len != 2'h0);
		next_test_on   = (test != AISD_TEST_OFF);
		next_test_code = {DATA_W{1'b0}};
		case (test)
			AISD_TEST_TOP: next_test_code = twos_i ? `AISD_CODE_TOP_TWOS : `AISD_CODE_TOP_BIN;
			AISD_TEST_MID: next_test_code = twos_i ? `AISD_CODE_MID_TWOS : `AISD_CODE_MID_BIN;
			AISD_TEST_BOT: next_test_code = twos_i ? `AISD_CODE_BOT_TWOS : `AISD_CODE_BOT_BIN;
			default:       next_test_code = {DATA_W{1'b0}};
		endcase
		if (next_test_on) begin
			next_src = AISD_SRC_NONE;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			word        <= `AISD_RESET_WORD;
			step        <= AISD_ST0;
			src_o       <= AISD_SRC_NONE;
			test_on_o   <= 1'b0;
			test_code_o <= {DATA_W{1'b0}};
			scanning_o  <= 1'b0;
			reserved_o  <= 1'b0;
			step_o      <= 1'b0;
			word_o      <= `AISD_RESET_WORD;
		end else begin
			word        <= next_word;
			step        <= next_step;
			src_o       <= next_src;
			test_on_o   <= next_test_on;
			test_code_o <= next_test_code;
			scanning_o  <= next_scanning;
			reserved_o  <= tbl_res; // Flag only; host must avoid these
			step_o      <= next_step_pulse;
			word_o      <= word;
		end
	end

	// Assertions
	property p_single_hold;
		@(posedge mclk_i) disable iff (rst_i)
		(sel == 5'b00010 && test == AISD_TEST_OFF && !write0) |=> (src_o == AISD_SRC_SECOND_POS);
	endproperty
	a_single_hold: assert property (p_single_hold) else $error("single-ended pick wrong");

	property p_diff_pick;
		@(posedge mclk_i) disable iff (rst_i)
		(sel == 5'b00101 && test == AISD_TEST_OFF) |=> (src_o == AISD_SRC_PAIR_B);
	endproperty
	a_diff_pick: assert property (p_diff_pick) else $error("differential pick wrong");

	property p_two_alt;
		@(posedge mclk_i) disable iff (rst_i)
		(sel == 5'b10001 && !write0 && step == AISD_ST1 && sample_i) |=> (step == AISD_ST0);
	endproperty
	a_two_alt: assert property (p_two_alt) else $error("two-input scan did not wrap");

	property p_three_wrap;
		@(posedge mclk_i) disable iff (rst_i)
		(sel == 5'b10010 && !write0 && step == AISD_ST2 && sample_i) |=> (step == AISD_ST0);
	endproperty
	a_three_wrap: assert property (p_three_wrap) else $error("three-input scan did not wrap");

	property p_four_step;
		@(posedge mclk_i) disable iff (rst_i)
		(sel == 5'b10011 && !write0 && step == AISD_ST2 && sample_i) |=> (step == AISD_ST3);
	endproperty
	a_four_step: assert property (p_four_step) else $error("four-input scan skipped");

	property p_mixed_two;
		@(posedge mclk_i) disable iff (rst_i)
		(sel == 5'b10101 && step == AISD_ST1 && test == AISD_TEST_OFF) |=> (src_o == AISD_SRC_PAIR_B);
	endproperty
	a_mixed_two: assert property (p_mixed_two) else $error("mixed scan step wrong");

	property p_mixed_three;
		@(posedge mclk_i) disable iff (rst_i)
		(sel == 5'b10110 && step == AISD_ST2 && test == AISD_TEST_OFF) |=> (src_o == AISD_SRC_PAIR_B);
	endproperty
	a_mixed_three: assert property (p_mixed_three) else $error("mixed three step wrong");

	property p_pairs;
		@(posedge mclk_i) disable iff (rst_i)
		(sel == 5'b11001 && step == AISD_ST0 && test == AISD_TEST_OFF) |=> (src_o == AISD_SRC_PAIR_A);
	endproperty
	a_pairs: assert property (p_pairs) else $error("pair scan step wrong");

	property p_no_scan_hold;
		@(posedge mclk_i) disable iff (rst_i)
		(!sel.scan && !write0) |=> (step == AISD_ST0) ##1 (!scanning_o);
	endproperty
	a_no_scan_hold: assert property (p_no_scan_hold) else $error("stepped without scan");

	property p_test_codes;
		@(posedge mclk_i) disable iff (rst_i)
		(test == AISD_TEST_MID && !twos_i) |=> (test_on_o && test_code_o == 10'h200);
	endproperty
	a_test_codes: assert property (p_test_codes) else $error("midpoint code wrong");

	property p_write_restart;
		@(posedge mclk_i) disable iff (rst_i)
		write0 |=> (step == AISD_ST0);
	endproperty
	a_write_restart: assert property (p_write_restart) else $error("scan not restarted");

	property p_three_third;
		@(posedge mclk_i) disable iff (rst_i)
		(sel == 5'b10010 && step == AISD_ST2 && test == AISD_TEST_OFF)
			|=> (src_o == AISD_SRC_SECOND_POS);
	endproperty
	a_three_third: assert property (p_three_third) else $error("third input wrong");

	property p_four_pulse;
		@(posedge mclk_i) disable iff (rst_i)
		(sel == 5'b10011 && sample_i && !write0) |=> step_o;
	endproperty
	a_four_pulse: assert property (p_four_pulse) else $error("no step pulse");

	property p_top_twos;
		@(posedge mclk_i) disable iff (rst_i)
		(test == AISD_TEST_TOP && twos_i) |=> (test_on_o && test_code_o == 10'h1FF);
	endproperty
	a_top_twos: assert property (p_top_twos) else $error("top code wrong");

	property p_bot_twos;
		@(posedge mclk_i) disable iff (rst_i)
		(test == AISD_TEST_BOT && twos_i) |=> (test_on_o && test_code_o == 10'h200);
	endproperty
	a_bot_twos: assert property (p_bot_twos) else $error("bottom code wrong");

	property p_normal_off;
		@(posedge mclk_i) disable iff (rst_i)
		(test == AISD_TEST_OFF) |=> (!test_on_o && test_code_o == 10'h000);
	endproperty
	a_normal_off: assert property (p_normal_off) else $error("test level while off");

	property p_test_replace;
		@(posedge mclk_i) disable iff (rst_i)
		(test != AISD_TEST_OFF) |=> (src_o == AISD_SRC_NONE);
	endproperty
	a_test_replace: assert property (p_test_replace) else $error("input not replaced");
endmodule
`default_nettype wire

// ==== aisd_host_model.sv ====
/*
 * Host model for the input select and test decoder: writes control words.
 * Assumes the bench calls write_word from one process only.
 */
`timescale 1ns/1ns
`default_nettype none
module aisd_host_model (
	input  wire logic       mclk_i,
	output logic            wr_o,
	output logic            reg_index_lo_o,
	output logic            reg_index_hi_o,
	output logic [9:0]      data_o
);
	initial begin
		wr_o = 1'b0;
		reg_index_lo_o = 1'b1;
		reg_index_hi_o = 1'b1;
		data_o = 10'h155;
	end

	// Released lines flip so stale data never passes for a fresh word
	task automatic write_word(input logic [1:0] idx, input logic [9:0] word);
		@(posedge mclk_i);
		wr_o <= 1'b1;
		reg_index_lo_o <= idx[0];
		reg_index_hi_o <= idx[1];
		data_o <= word;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		reg_index_lo_o <= ~idx[0];
		reg_index_hi_o <= ~idx[1];
		data_o <= ~word;
	endtask
endmodule
`default_nettype wire

// ==== aisd_pkg.sv ====
/*
 * Types for the input select and test decoder.
 * Assumes aisd_cfg.svh is on the include path.
 */
`default_nettype none
package aisd_pkg;
	typedef enum logic [2:0] {
		AISD_SRC_FIRST_POS  = 3'h0,
		AISD_SRC_FIRST_NEG  = 3'h1,
		AISD_SRC_SECOND_POS = 3'h2,
		AISD_SRC_SECOND_NEG = 3'h3,
		AISD_SRC_PAIR_A     = 3'h4,
		AISD_SRC_PAIR_B     = 3'h5,
		AISD_SRC_NONE       = 3'h7
	} aisd_src_t;

	typedef enum logic [1:0] {
		AISD_TEST_OFF = 2'h0,
		AISD_TEST_TOP = 2'h1,
		AISD_TEST_MID = 2'h2,
		AISD_TEST_BOT = 2'h3
	} aisd_test_t;

	// Scan step, Gray along 0-1-3-2
	typedef enum logic [1:0] {
		AISD_ST0 = 2'h0,
		AISD_ST1 = 2'h1,
		AISD_ST2 = 2'h3,
		AISD_ST3 = 2'h2
	} aisd_step_t;

	typedef struct packed {
		logic       scan;
		logic [1:0] pair;
		logic [1:0] pick;
	} aisd_sel_t;

	typedef struct packed {
		aisd_src_t  src;
		aisd_test_t test;
		logic       scanning;
		logic       reserved;
	} aisd_route_t;
endpackage
`default_nettype wire

// ==== aisd_seq_table.sv ====
/*
 * Pure decode of selection bits and scan step into the input to convert.
 * Assumes the caller registers the result and owns the step counter.
 */
`include "aisd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module aisd_seq_table
	import aisd_pkg::*;
(
	input  wire aisd_sel_t  sel_i,
	input  wire aisd_step_t step_i,
	output aisd_src_t       src_o,
	output logic [1:0]      len_o,
	output logic            reserved_o
);
	always_comb begin
		src_o      = AISD_SRC_NONE;
		len_o      = 2'h0;
		reserved_o = 1'b0;
		case ({sel_i.scan, sel_i.pair})
			3'b000: begin
				src_o = aisd_src_t'({1'b0, sel_i.pick});
			end
			3'b001: begin
				case (sel_i.pick)
					2'h0: src_o = AISD_SRC_PAIR_A;
					2'h1: src_o = AISD_SRC_PAIR_B;
					default: reserved_o = 1'b1;
				endcase
			end
			3'b100: begin
				len_o = sel_i.pick;
				case (step_i)
					AISD_ST0: src_o = AISD_SRC_FIRST_POS;
					AISD_ST1: src_o = AISD_SRC_FIRST_NEG;
					AISD_ST2: src_o = AISD_SRC_SECOND_POS;
					AISD_ST3: src_o = AISD_SRC_SECOND_NEG;
					default: src_o = AISD_SRC_NONE;
				endcase
				if (sel_i.pick == 2'h0) begin
					reserved_o = 1'b1;
				end
			end
			3'b101: begin
				if (sel_i.pick == 2'h1) begin
					len_o = 2'h1;
					src_o = (step_i == AISD_ST0) ? AISD_SRC_FIRST_POS : AISD_SRC_PAIR_B;
				end else if (sel_i.pick == 2'h2) begin
					len_o = 2'h2;
					case (step_i)
						AISD_ST0: src_o = AISD_SRC_FIRST_POS;
						AISD_ST1: src_o = AISD_SRC_FIRST_NEG;
						default:  src_o = AISD_SRC_PAIR_B;
					endcase
				end else begin
					reserved_o = 1'b1;
				end
			end
			3'b110: begin
				if (sel_i.pick == 2'h1) begin
					len_o = 2'h1;
					src_o = (step_i == AISD_ST0) ? AISD_SRC_PAIR_A : AISD_SRC_PAIR_B;
				end else begin
					reserved_o = 1'b1;
				end
			end
			default: reserved_o = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// ==== test_adc_input_select_and_test_decoder.sv ====
/*
 * Self-checking bench for aisd_core: every valid selection, random test levels.
 * Assumes aisd_pkg, aisd_core and aisd_host_model are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
module test_adc_input_select_and_test_decoder
	import aisd_pkg::*;
;
	logic              mclk_i;
	logic              rst_i;
	logic              wr;
	logic              idx_lo;
	logic              idx_hi;
	logic [9:0]        data;
	logic              sample;
	logic              twos;
	aisd_src_t         src;
	logic              test_on;
	logic [9:0]        test_code;
	logic              scanning;
	logic              reserved;
	logic              step;
	logic [9:0]        word;
	int                error_cnt = 0;
	int                cmp_count = 0;
	int                cycles = 0;
	int                i;
	int                k;
	int                hits;
	logic [4:0]        s;
	logic [1:0]        t;
	logic [9:0]        w;
	logic [4:0]        codes [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
		5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};

	aisd_host_model host (.mclk_i(mclk_i), .wr_o(wr), .reg_index_lo_o(idx_lo),
		.reg_index_hi_o(idx_hi), .data_o(data));

	aisd_core #(.DATA_W(10)) DUT (.mclk_i(mclk_i), .rst_i(rst_i), .wr_i(wr),
		.reg_index_lo_i(idx_lo), .reg_index_hi_i(idx_hi), .data_i(data),
		.sample_i(sample), .twos_i(twos), .src_o(src), .test_on_o(test_on),
		.test_code_o(test_code), .scanning_o(scanning), .reserved_o(reserved),
		.step_o(step), .word_o(word));

	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	task automatic print_verdict;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Scan sequence per selection code and step count
	function automatic logic [2:0] exp_src(input logic [4:0] c, input int n);
		case (c)
			5'h04: return 3'h4;
			5'h05: return 3'h5;
			5'h11: return 3'(n % 2);
			5'h12: return 3'(n % 3);
			5'h13: return 3'(n % 4);
			5'h15: return (n % 2 == 1) ? 3'h5 : 3'h0;
			5'h16: return (n % 3 == 2) ? 3'h5 : 3'(n % 3);
			5'h19: return (n % 2 == 1) ? 3'h5 : 3'h4;
			default: return {1'b0, c[1:0]};
		endcase
	endfunction

	function automatic logic [9:0] exp_code(input logic [1:0] c, input logic tw);
		case (c)
			2'h1: return tw ? 10'h1FF : 10'h3FF;
			2'h2: return tw ? 10'h000 : 10'h200;
			2'h3: return tw ? 10'h200 : 10'h000;
			default: return 10'h000;
		endcase
	endfunction

	task automatic report(input logic ok, input logic [9:0] got, input logic [9:0] exp);
		cmp_count++;
		if (!ok) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_src(input logic [2:0] got, input logic [2:0] exp);
		report(got === exp, 10'(got), 10'(exp));
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		report(got === exp, 10'(got), 10'(exp));
	endtask

	task automatic chk_word(input logic [9:0] got, input logic [9:0] exp);
		report(got === exp, got, exp);
	endtask

	task automatic check_state(input int n);
		chk_bit(test_on, t != 2'h0);
		chk_word(test_code, exp_code(t, twos));
		chk_src(src, (t != 2'h0) ? 3'h7 : exp_src(s, n));
		chk_word(word, w);
		if (t == 2'h0) begin
			chk_bit(scanning, s[4]);
			chk_bit(reserved, 1'b0);
		end
	endtask

	// Step pulse is counted over two edges so its exact edge is not pinned
	task automatic sample_pulse;
		@(posedge mclk_i);
		sample <= 1'b1;
		@(posedge mclk_i);
		sample <= 1'b0;
		#1 hits = int'(step === 1'b1);
		@(posedge mclk_i);
		#1 hits += int'(step === 1'b1);
	endtask

	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		rst_i = 1'b1;
		sample = 1'b0;
		twos = 1'b0;
		void'($urandom(32'h946C3BDD));
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1 chk_word(word, 10'h020);
		chk_src(src, 3'h4);
		for (i = 0; i < 40; i++) begin
			s = (i < 12) ? codes[i] : codes[$urandom_range(11)];
			t = (i < 12) ? 2'h0 : 2'($urandom_range(3));
			w = {t, s, 3'($urandom_range(7))};
			@(posedge mclk_i);
			twos <= 1'($urandom_range(1));
			host.write_word(2'h0, w);
			repeat (2) @(posedge mclk_i);
			#1 check_state(0);
			if (i % 4 == 0) begin
				host.write_word(2'($urandom_range(3, 1)), ~w);
				repeat (2) @(posedge mclk_i);
				#1 chk_word(word, w);
			end
			for (k = 1; k <= 5; k++) begin
				sample_pulse();
				check_state(k);
				if (t == 2'h0) begin
					chk_word(10'(hits), {9'h000, s[4]});
				end
			end
		end
		print_verdict();
	end
endmodule
`default_nettype wire
